// ==== core/mcp_fsm.sv ====
// Command and fault priority state machine of the motion controller
`timescale 1ns/10ps
`default_nettype none
module mcp_fsm
  import mcp_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire mcp_cmd_t         cmd,
  input  wire mcp_fault_t       fault,
  input  wire mcp_param_t       otp_data,
  input  wire logic             motion_done,
  input  wire logic             homing_second,
  input  wire logic [POS_W-1:0] actual_position,
  output var  mcp_state_t       state_r,
  output var  logic [POS_W-1:0] target_position_r,
  output var  logic             actual_clear_r,
  output var  logic             otp_refresh_r,
  output var  logic             halt_exit_r,
  output var  logic             secure_enable_r,
  output var  logic             secure_travel_en_r,
  output var  mcp_flags_t       flags_r,
  output var  mcp_param_t       ram_params_r,
  output var  mcp_param_t       home_params_r,
  output var  mcp_param_t       eff_params_r
);

  mcp_state_t state_nxt;

  logic c_status1;
  logic c_otp_read;
  logic c_reload;
  logic c_write;
  logic c_zero;
  logic c_load;
  logic c_safe;
  logic c_home;
  logic c_abrupt;
  logic c_ramped;

  always_comb begin
    c_status1  = cmd.valid && cmd.code == CMD_STATUS1;
    c_otp_read = cmd.valid && cmd.code == CMD_OTP_READ;
    c_reload   = cmd.valid && cmd.code == CMD_RELOAD;
    c_write    = cmd.valid && cmd.code == CMD_WRITE_PARAMS;
    c_zero     = cmd.valid && cmd.code == CMD_ZERO;
    c_load     = cmd.valid && cmd.code == CMD_LOAD_TARGET;
    c_safe     = cmd.valid && cmd.code == CMD_GO_SAFE;
    c_home     = cmd.valid && cmd.code == CMD_HOMING;
    c_abrupt   = cmd.valid && cmd.code == CMD_ABRUPT;
    c_ramped   = cmd.valid && cmd.code == CMD_RAMPED;
  end

  logic sec_en;
  logic tgt_state;
  logic load_ok;
  logic safe_ok;
  logic zero_ok;
  logic in_halt;
  logic halt_done;
  logic abrupt_evt;
  logic causes_gone;
  logic home_start;

  assign sec_en    = ram_params_r.secure_position != SEC_DISABLED;
  assign tgt_state = state_r == ST_IDLE || state_r == ST_MOVE ||
                     state_r == ST_HOME;
  assign load_ok   = tgt_state && c_load && !flags_r.step_loss;
  assign safe_ok   = tgt_state && c_safe && sec_en &&
                     !flags_r.step_loss;
  assign zero_ok   = c_zero &&
                     (state_r == ST_IDLE || state_r == ST_DOWN);
  assign in_halt   = state_r == ST_RHALT || state_r == ST_AHALT;
  assign halt_done = in_halt && state_nxt == ST_IDLE;
  assign abrupt_evt = c_abrupt && (state_r == ST_MOVE ||
                      state_r == ST_HOME || state_r == ST_RHALT);
  // Powered-down is left on this read only when every hard and thermal cause is already gone
  assign causes_gone = !(fault.charge_pump_fail ||
                         fault.undervoltage_shutdown ||
                         fault.electrical_defect || fault.over_temp);
  assign home_start = state_r == ST_IDLE && state_nxt == ST_HOME;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (flags_r.hard_halt_flag) begin
          state_nxt = ST_DOWN;
        end else if (flags_r.thermal) begin
          state_nxt = ST_DOWN;
        end else if (c_home) begin
          state_nxt = ST_HOME;
        end else if (load_ok || safe_ok) begin
          state_nxt = ST_MOVE;
        end else if (!halt_exit_r &&
                     actual_position != target_position_r) begin
          state_nxt = ST_MOVE;
        end
      end
      ST_MOVE: begin
        if (c_abrupt || flags_r.hard_halt_flag) begin
          state_nxt = ST_AHALT;
        end else if (c_ramped || flags_r.thermal) begin
          state_nxt = ST_RHALT;
        end else if (motion_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_HOME: begin
        if (c_abrupt || flags_r.hard_halt_flag) begin
          state_nxt = ST_AHALT;
        end else if (flags_r.thermal) begin
          state_nxt = ST_RHALT;
        end else if (motion_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_RHALT: begin
        if (c_abrupt || flags_r.hard_halt_flag) begin
          state_nxt = ST_AHALT;
        end else if (motion_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_AHALT: begin
        if (motion_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_DOWN: begin
        if (c_status1 && causes_gone) begin
          state_nxt = ST_IDLE;
        end
      end
      // Unused codes fall back to powered-down
      default: begin
        state_nxt = ST_DOWN;
      end
    endcase
  end

  // Reset lands in powered-down so the host must read status first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_DOWN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      target_position_r <= POS_ZERO;
    end else if (zero_ok) begin
      target_position_r <= POS_ZERO;
    end else if (halt_done) begin
      target_position_r <= actual_position;
    end else if (load_ok) begin
      target_position_r <= cmd.position;
    end else if (safe_ok) begin
      target_position_r <= {ram_params_r.secure_position,
                            {SEC_LSB_W{1'b0}}};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      actual_clear_r <= 1'b0;
    end else begin
      actual_clear_r <= zero_ok;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      otp_refresh_r <= 1'b0;
    end else begin
      otp_refresh_r <= c_reload || c_otp_read;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      halt_exit_r <= 1'b0;
    end else if (in_halt && state_nxt != state_r) begin
      halt_exit_r <= 1'b1;
    end else if (state_r == ST_IDLE) begin
      halt_exit_r <= 1'b0;
    end
  end

  // Secure travel is only offered while no step loss is pending
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      secure_enable_r    <= 1'b0;
      secure_travel_en_r <= 1'b0;
    end else begin
      secure_enable_r    <= sec_en;
      secure_travel_en_r <= sec_en && !flags_r.step_loss;
    end
  end

  mcp_fault_flags u_flags (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .fault       (fault),
    .status_read (c_status1),
    .abrupt_evt  (abrupt_evt),
    .flags_r     (flags_r)
  );

  // RAM copy stays the status view even mid-homing
  mcp_param_store u_params (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .reload        (c_reload),
    .write_params  (c_write),
    .home_start    (home_start),
    .homing_active (state_r == ST_HOME),
    .homing_second (homing_second),
    .cmd_params    (cmd.params),
    .otp_data      (otp_data),
    .ram_r         (ram_params_r),
    .home_r        (home_params_r),
    .eff_r         (eff_params_r)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_halt_leave;
    (state_r == ST_RHALT || state_r == ST_AHALT) ##1 state_r == ST_IDLE;
  endsequence

  sequence s_flag_pulse;
    halt_exit_r ##1 !halt_exit_r;
  endsequence

  a_down_needs_read: assert property (
    (state_r == ST_DOWN && !c_status1) |=> state_r == ST_DOWN)
    else $error("left powered-down without status read");

  a_down_flags_hold: assert property (
    (state_r == ST_DOWN && !causes_gone) |=> state_r == ST_DOWN)
    else $error("left powered-down with fault present");

  a_target_load: assert property (
    (load_ok && !zero_ok && !halt_done) |=>
      target_position_r == $past(cmd.position))
    else $error("target not loaded by load command");

  a_steploss_hold: assert property (
    (flags_r.step_loss && (c_load || c_safe) && !zero_ok && !halt_done)
      |=> $stable(target_position_r))
    else $error("target changed during step loss");

  a_abrupt_wins: assert property (
    (state_r == ST_MOVE && c_abrupt) |=>
      state_r == ST_AHALT && flags_r.step_loss)
    else $error("abrupt halt not taken with step loss");

  a_hard_idle_down: assert property (
    (state_r == ST_IDLE && flags_r.hard_halt_flag) |=> state_r == ST_DOWN)
    else $error("hard halt in idle did not power down");

  a_thermal_ramp: assert property (
    (state_r == ST_MOVE && flags_r.thermal && !c_abrupt &&
     !flags_r.hard_halt_flag) |=> state_r == ST_RHALT)
    else $error("thermal fault did not start ramped halt");

  a_halt_exit_flag: assert property (
    s_halt_leave |-> s_flag_pulse)
    else $error("halt exit flag not pulsed on leaving halt");

  a_idle_mismatch: assert property (
    (state_r == ST_IDLE && !halt_exit_r && !flags_r.hard_halt_flag &&
     !flags_r.thermal && actual_position != target_position_r)
      |=> state_r == ST_MOVE || state_r == ST_HOME)
    else $error("position mismatch in idle did not start move");

  a_sec_disabled: assert property (
    ram_params_r.secure_position == SEC_DISABLED |=> !secure_enable_r)
    else $error("secure enable set for disabled code");

  a_zero_idle: assert property (
    (c_zero && state_r == ST_IDLE) |=>
      target_position_r == POS_ZERO && actual_clear_r)
    else $error("zero command did not clear positions");

  a_halt_copy: assert property (
    (state_r == ST_AHALT && motion_done) |=>
      state_r == ST_IDLE && target_position_r == $past(actual_position))
    else $error("halt end did not copy actual position");

  a_sec_enabled: assert property (
    ram_params_r.secure_position != SEC_DISABLED |=> secure_enable_r)
    else $error("secure enable clear for valid code");

  a_travel_block: assert property (
    flags_r.step_loss |=> !secure_travel_en_r)
    else $error("secure travel offered during step loss");

  a_home_idle_only: assert property (
    (state_r != ST_IDLE && state_r != ST_HOME) |=> state_r != ST_HOME)
    else $error("homing entered from a state other than idle");

  a_reload_target: assert property (
    (c_reload && !halt_done) |=> $stable(target_position_r))
    else $error("reload altered target position");

endmodule : mcp_fsm
`default_nettype wire

// ==== core/mcp_pkg.sv ====
// Shared types and constants of the motion command priority block
// Operation
// - Reload refreshes memory, clears accel shape
// - Parameter write updates RAM in all states
// - Target loads in idle, moving, homing only
// - Hard faults set halt flag; idle goes down, motion abrupt halts
// - Thermal fault: idle down, motion ramps halt
// - Start powered down; leave after status read
// - Homing uses own set copied at start
// - Second homing motion forces accel shape one
// - Status read shows RAM velocities, not homing
// - Stay down until thermal and halt clear
// - Flags clear on read when cause gone
// - Writes during homing leave run untouched
// - Secure enable unless secure code most negative
// - Halt exit set leaving halts, cleared idle
// - Idle position mismatch starts move, lowest priority
// - Step loss blocks target loads, secure travel
// - Homing, zero still run; zero idle/down only
// - Step loss cleared only by status read
// - Abrupt beats ramped beats target reached
package mcp_pkg;

  localparam int POS_W     = 16;
  localparam int SEC_W     = 11;
  localparam int SEC_LSB_W = POS_W - SEC_W;
  localparam int NIB_W     = 4;

  localparam logic [SEC_W-1:0] SEC_DISABLED = 11'h400;
  localparam logic [POS_W-1:0] POS_ZERO     = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_MOVE, ST_HOME, ST_RHALT, ST_AHALT, ST_DOWN
  } mcp_state_t;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_STATUS1, CMD_STATUS2, CMD_OTP_READ, CMD_RELOAD,
    CMD_WRITE_PARAMS, CMD_ZERO, CMD_LOAD_TARGET, CMD_GO_SAFE,
    CMD_HOMING, CMD_ABRUPT, CMD_RAMPED
  } mcp_cmd_code_t;

  typedef struct packed {
    logic             accel_shape;
    logic             shaft;
    logic [NIB_W-1:0] irun;
    logic [NIB_W-1:0] ihold;
    logic [NIB_W-1:0] vmin;
    logic [NIB_W-1:0] vmax;
    logic [NIB_W-1:0] acc;
    logic [SEC_W-1:0] secure_position;
    logic [1:0]       step_mode;
  } mcp_param_t;

  localparam mcp_param_t PARAM_RST = '0;

  typedef struct packed {
    logic             valid;
    mcp_cmd_code_t    code;
    logic [POS_W-1:0] position;
    mcp_param_t       params;
  } mcp_cmd_t;

  typedef struct packed {
    logic charge_pump_fail;
    logic undervoltage_shutdown;
    logic electrical_defect;
    logic over_temp;
    logic over_current;
  } mcp_fault_t;

  typedef struct packed {
    logic supply_reset_flag;
    logic step_loss;
    logic thermal;
    logic hard_halt_flag;
  } mcp_flags_t;

endpackage : mcp_pkg

// ==== core/mcp_fault_flags.sv ====
// Sticky fault and status flags cleared by the status read
`timescale 1ns/10ps
`default_nettype none
module mcp_fault_flags
  import mcp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire mcp_fault_t fault,
  input  wire logic       status_read,
  input  wire logic       abrupt_evt,
  output var  mcp_flags_t flags_r
);

  logic hard_cause;
  assign hard_cause = fault.charge_pump_fail | fault.undervoltage_shutdown |
                      fault.electrical_defect;

  // Set wins over clear, so a flag only drops once its cause is gone
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_r.hard_halt_flag <= 1'b0;
    end else if (hard_cause) begin
      flags_r.hard_halt_flag <= 1'b1;
    end else if (status_read) begin
      flags_r.hard_halt_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_r.thermal <= 1'b0;
    end else if (fault.over_temp) begin
      flags_r.thermal <= 1'b1;
    end else if (status_read) begin
      flags_r.thermal <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_r.step_loss <= 1'b0;
    end else if (fault.undervoltage_shutdown | fault.over_current |
                 fault.over_temp | abrupt_evt) begin
      flags_r.step_loss <= 1'b1;
    end else if (status_read) begin
      flags_r.step_loss <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_r.supply_reset_flag <= 1'b1;
    end else if (status_read) begin
      flags_r.supply_reset_flag <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_sl_read_only: assert property (
    $fell(flags_r.step_loss) |-> $past(status_read))
    else $error("step loss cleared without status read");

  a_hard_cause_set: assert property (
    hard_cause |=> flags_r.hard_halt_flag [*2] or
      (flags_r.hard_halt_flag ##1 1'b1))
    else $error("hard halt flag not set by fault");

  a_flag_cause_hold: assert property (
    (status_read && fault.over_temp) |=> flags_r.thermal)
    else $error("thermal flag cleared while cause present");

endmodule : mcp_fault_flags
`default_nettype wire

// ==== core/mcp_param_store.sv ====
// Parameter RAM, homing parameter set and effective parameter view
`timescale 1ns/10ps
`default_nettype none
module mcp_param_store
  import mcp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       reload,
  input  wire logic       write_params,
  input  wire logic       home_start,
  input  wire logic       homing_active,
  input  wire logic       homing_second,
  input  wire mcp_param_t cmd_params,
  input  wire mcp_param_t otp_data,
  output var  mcp_param_t ram_r,
  output var  mcp_param_t home_r,
  output var  mcp_param_t eff_r
);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ram_r <= PARAM_RST;
    end else if (reload) begin
      ram_r             <= otp_data;
      ram_r.accel_shape <= 1'b0;
    end else if (write_params) begin
      ram_r                 <= cmd_params;
      ram_r.secure_position <= ram_r.secure_position;
      ram_r.step_mode       <= ram_r.step_mode;
    end
  end

  // Frozen for the whole run so RAM writes wait for the next move
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      home_r <= PARAM_RST;
    end else if (home_start) begin
      home_r      <= ram_r;
      home_r.vmin <= cmd_params.vmin;
      home_r.vmax <= cmd_params.vmax;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eff_r <= PARAM_RST;
    end else if (homing_active) begin
      eff_r             <= home_r;
      eff_r.accel_shape <= homing_second | home_r.accel_shape;
    end else begin
      eff_r <= ram_r;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_home_shape_one: assert property (
    (homing_active && homing_second) |=> eff_r.accel_shape)
    else $error("accel shape not forced during second homing motion");

  a_home_set_frozen: assert property (
    (!home_start && write_params) |=> $stable(home_r))
    else $error("homing set altered by parameter write");

  a_home_copy_acc: assert property (
    home_start |=> home_r.acc == $past(ram_r.acc))
    else $error("homing set not copied from RAM at start");

  a_reload_shape: assert property (
    reload |=> !ram_r.accel_shape && ram_r.vmax == $past(otp_data.vmax))
    else $error("reload did not copy defaults and clear shape");

  a_write_ram: assert property (
    (write_params && !reload) |=> ram_r.acc == $past(cmd_params.acc))
    else $error("parameter write did not update RAM");

endmodule : mcp_param_store
`default_nettype wire

// ==== dv/mcp_host_model.sv ====
// Host side model issuing serial commands to the priority block
`timescale 1ns/10ps
`default_nettype none
module mcp_host_model
  import mcp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire mcp_state_t state,
  output var  mcp_cmd_t   cmd
);
  mcp_param_t last_prm;

  initial begin
    cmd      = '0;
    last_prm = PARAM_RST;
  end

  // One-cycle pulse after an edge; a spare cycle keeps drivers apart
  task automatic send(input mcp_cmd_code_t    code,
                      input logic [POS_W-1:0] pos,
                      input mcp_param_t       prm);
    mcp_param_t p;
    p = prm;
    if (code == CMD_WRITE_PARAMS && state == ST_MOVE) begin
      p.acc  = last_prm.acc;
      p.vmin = last_prm.vmin;
    end
    if (code == CMD_WRITE_PARAMS) last_prm = p;
    @(posedge sys_clk);
    #1;
    cmd.valid    = 1'b1;
    cmd.code     = code;
    cmd.position = pos;
    cmd.params   = p;
    @(posedge sys_clk);
    #1;
    cmd.valid = 1'b0;
  endtask : send
endmodule : mcp_host_model
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking testbench of the command priority state machine
`timescale 1ns/10ps
`default_nettype none
module tb
  import mcp_pkg::*;
;
  logic             sys_clk;
  logic             rst;
  mcp_cmd_t         cmd;
  mcp_fault_t       fault;
  mcp_param_t       otp_data;
  logic             motion_done;
  logic             homing_second;
  logic [POS_W-1:0] actual_position;
  mcp_state_t       state_r;
  logic [POS_W-1:0] target_position_r;
  logic             actual_clear_r;
  logic             otp_refresh_r;
  logic             halt_exit_r;
  logic             secure_enable_r;
  logic             secure_travel_en_r;
  mcp_flags_t       flags_r;
  mcp_param_t       ram_r;
  mcp_param_t       home_r;
  mcp_param_t       eff_r;
  mcp_param_t       wp;
  mcp_param_t       hp;
  int               err_count;
  int               total_checks;
  int               cyc;

  mcp_fsm mcp_fsm_i (
    .sys_clk(sys_clk), .rst(rst), .cmd(cmd), .fault(fault),
    .otp_data(otp_data), .motion_done(motion_done),
    .homing_second(homing_second), .actual_position(actual_position),
    .state_r(state_r), .target_position_r(target_position_r),
    .actual_clear_r(actual_clear_r), .otp_refresh_r(otp_refresh_r),
    .halt_exit_r(halt_exit_r), .secure_enable_r(secure_enable_r),
    .secure_travel_en_r(secure_travel_en_r), .flags_r(flags_r),
    .ram_params_r(ram_r), .home_params_r(home_r), .eff_params_r(eff_r)
  );

  mcp_host_model mcp_host_model_i (
    .sys_clk(sys_clk), .state(state_r), .cmd(cmd)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  // Hang guard sized well above the whole sequence
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic cmdo(input mcp_cmd_code_t c);
    mcp_host_model_i.send(c, 16'h0000, PARAM_RST);
  endtask : cmdo

  task automatic fin;
    @(posedge sys_clk);
    #1 motion_done = 1'b1;
    @(posedge sys_clk);
    #1 motion_done = 1'b0;
  endtask : fin

  // Fault flags are registered, so the state follows a few edges later
  task automatic wait_st(input mcp_state_t s);
    int n;
    n = 0;
    while (state_r !== s && n < 8) begin
      @(posedge sys_clk);
      #1 n++;
    end
  endtask : wait_st

  initial begin
    cyc = 0;
    err_count = 0;
    total_checks = 0;
    rst = 1'b1;
    fault = '0;
    otp_data = PARAM_RST;
    motion_done = 1'b0;
    homing_second = 1'b0;
    actual_position = 16'h0000;
    otp_data.secure_position = 11'h400;
    wp = PARAM_RST;
    wp.irun = 4'h5;
    wp.acc = 4'h6;
    wp.vmin = 4'h1;
    wp.vmax = 4'h2;
    wp.secure_position = 11'h7ff;
    wp.step_mode = 2'h3;
    hp = PARAM_RST;
    hp.vmin = 4'h3;
    hp.vmax = 4'h9;
    repeat (6) @(posedge sys_clk);
    #1 rst = 1'b0;
    chk("state", ST_DOWN, state_r);
    chk("supply", 1, flags_r.supply_reset_flag);
    mcp_host_model_i.send(CMD_LOAD_TARGET, 16'h0040, PARAM_RST);
    chk("target", 16'h0000, target_position_r);
    cmdo(CMD_ZERO);
    chk("act_clr", 1, actual_clear_r);
    cmdo(CMD_STATUS1);
    chk("state", ST_IDLE, state_r);
    chk("supply", 0, flags_r.supply_reset_flag);
    mcp_host_model_i.send(CMD_WRITE_PARAMS, 16'h0000, wp);
    chk("irun", 4'h5, ram_r.irun);
    chk("secure_position", PARAM_RST.secure_position, ram_r.secure_position);
    cmdo(CMD_OTP_READ);
    chk("otp_ref", 1, otp_refresh_r);
    chk("irun", 4'h5, ram_r.irun);
    $display("test power up done");

    mcp_host_model_i.send(CMD_LOAD_TARGET, 16'h0120, PARAM_RST);
    chk("state", ST_MOVE, state_r);
    chk("target", 16'h0120, target_position_r);
    actual_position = 16'h0120;
    fin();
    chk("state", ST_IDLE, state_r);
    actual_position = 16'h0100;
    repeat (2) @(posedge sys_clk);
    #1 chk("state", ST_MOVE, state_r);
    fork
      cmdo(CMD_ABRUPT);
      fin();
    join
    chk("state", ST_AHALT, state_r);
    chk("steploss", 1, flags_r.step_loss);
    fin();
    chk("state", ST_IDLE, state_r);
    chk("target", 16'h0100, target_position_r);
    chk("hexit", 1, halt_exit_r);
    @(posedge sys_clk);
    #1 chk("hexit", 0, halt_exit_r);
    mcp_host_model_i.send(CMD_LOAD_TARGET, 16'h0200, PARAM_RST);
    chk("target", 16'h0100, target_position_r);
    $display("test abrupt halt done");

    mcp_host_model_i.send(CMD_HOMING, 16'h0000, hp);
    chk("state", ST_HOME, state_r);
    chk("h_vmin", 4'h3, home_r.vmin);
    chk("h_irun", 4'h5, home_r.irun);
    chk("r_vmax", 4'h2, ram_r.vmax);
    wp.irun = 4'ha;
    mcp_host_model_i.send(CMD_WRITE_PARAMS, 16'h0000, wp);
    chk("h_irun", 4'h5, home_r.irun);
    chk("irun", 4'ha, ram_r.irun);
    cmdo(CMD_RAMPED);
    chk("state", ST_HOME, state_r);
    cmdo(CMD_ZERO);
    chk("act_clr", 0, actual_clear_r);
    homing_second = 1'b1;
    cmdo(CMD_RELOAD);
    chk("otp_ref", 1, otp_refresh_r);
    chk("shape", 0, ram_r.accel_shape);
    chk("target", 16'h0100, target_position_r);
    repeat (2) @(posedge sys_clk);
    #1 chk("eff_shp", 1, eff_r.accel_shape);
    homing_second = 1'b0;
    fin();
    chk("state", ST_IDLE, state_r);
    repeat (2) @(posedge sys_clk);
    #1 chk("eff_shp", 0, eff_r.accel_shape);
    cmdo(CMD_STATUS1);
    chk("steploss", 0, flags_r.step_loss);
    chk("sec_en", 0, secure_enable_r);
    cmdo(CMD_GO_SAFE);
    chk("target", 16'h0100, target_position_r);
    $display("test homing done");

    otp_data.secure_position = 11'h123;
    cmdo(CMD_RELOAD);
    repeat (2) @(posedge sys_clk);
    #1 chk("sec_en", 1, secure_enable_r);
    chk("travel", 1, secure_travel_en_r);
    cmdo(CMD_GO_SAFE);
    chk("target", 16'h2460, target_position_r);
    chk("state", ST_MOVE, state_r);
    cmdo(CMD_RAMPED);
    chk("state", ST_RHALT, state_r);
    cmdo(CMD_ABRUPT);
    chk("state", ST_AHALT, state_r);
    actual_position = 16'h2000;
    fin();
    chk("target", 16'h2000, target_position_r);
    chk("travel", 0, secure_travel_en_r);
    cmdo(CMD_STATUS1);
    $display("test secure and halts done");

    for (int i = 0; i < 3; i++) begin
      fault = mcp_fault_t'(5'h10 >> i);
      wait_st(ST_DOWN);
      chk("state", ST_DOWN, state_r);
      chk("hhalt", 1, flags_r.hard_halt_flag);
      cmdo(CMD_STATUS1);
      chk("state", ST_DOWN, state_r);
      fault = '0;
      cmdo(CMD_STATUS1);
      chk("state", ST_IDLE, state_r);
      chk("hhalt", 0, flags_r.hard_halt_flag);
    end
    mcp_host_model_i.send(CMD_LOAD_TARGET, 16'h3000, PARAM_RST);
    fault.over_temp = 1'b1;
    wait_st(ST_RHALT);
    chk("state", ST_RHALT, state_r);
    fin();
    wait_st(ST_DOWN);
    chk("state", ST_DOWN, state_r);
    cmdo(CMD_STATUS1);
    chk("state", ST_DOWN, state_r);
    fault = '0;
    cmdo(CMD_STATUS1);
    chk("state", ST_IDLE, state_r);
    chk("thermal", 0, flags_r.thermal);
    $display("test faults done");
    results();
  end
endmodule : tb
`default_nettype wire
